// ==== rtl/tbm_defines.svh ====
// register offsets, field positions, reset values and select codes for the
// framing and monitor pin block; included by every design file of the block except the package.
// Notes on behaviour
// - Select codes 0h and 1h leave the monitor output pin undriven.
// - Select code 2h drives the monitor pin low and code 3h drives it high.
// - Select code 4h shows the transmit envelope and code 5h shows transmitter activity.
// - Select code 6h shows the generic secure-link signal.
// - Select code 7h shows the receive envelope, meaningful only for type A at 106 kBd.
// - Select code 8h shows receiver activity and code 9h shows the received bit stream.
// - Bit 7 of the monitor control register puts the I/O pads into fast switching.
// - Bit 7 of the framing register sends each byte high bit first, else low bit first.
// - Bit 5 of the framing register selects odd parity when set and even parity when clear.
// - Bit 3 of the framing register gives the level of the stop bit.
// - Bit 1 of the framing register gives the level of the start bit.
// - Bit 0 of the framing register inserts a start bit when set and omits it when clear.
`ifndef TBM_DEFINES_SVH
`define TBM_DEFINES_SVH

`define TBM_ADDR_MONITOR 8'h47
`define TBM_ADDR_FRAMING 8'h48

`define TBM_MON_MASK 8'h8f
`define TBM_FRM_MASK 8'hab
`define TBM_MON_RESET 8'h00
`define TBM_FRM_RESET 8'h00

`define TBM_MON_FAST_BIT 7
`define TBM_MON_SEL_MSB 3
`define TBM_MON_SEL_LSB 0

`define TBM_FRM_HIGH_FIRST_BIT 7
`define TBM_FRM_PARITY_BIT 5
`define TBM_FRM_STOP_BIT 3
`define TBM_FRM_START_LEVEL_BIT 1
`define TBM_FRM_START_INSERT_BIT 0

`define TBM_SEL_LOW 4'h2
`define TBM_SEL_HIGH 4'h3
`define TBM_SEL_TX_ENV 4'h4
`define TBM_SEL_TX_ACTIVE 4'h5
`define TBM_SEL_SECURE 4'h6
`define TBM_SEL_RX_ENV 4'h7
`define TBM_SEL_RX_ACTIVE 4'h8
`define TBM_SEL_RX_BIT 4'h9

`define TBM_LAST_DATA_IDX 3'h7
`define TBM_FRAME_LEN_PLAIN 4'ha
`define TBM_FRAME_LEN_INSERT 4'hb

`endif

// ==== rtl/tbm_pkg.sv ====
// types shared by the framing and monitor pin block.
// assumes nothing beyond a SystemVerilog compiler.
package tbm_pkg;

	typedef struct packed {
		logic rx_env;
		logic rx_active;
		logic rx_bit;
	} tbm_rx_sig_t;

	typedef struct packed {
		logic tx_env;
		logic tx_active;
		logic secure;
		logic rx_env;
		logic rx_active;
		logic rx_bit;
	} tbm_mon_src_t;

	typedef struct packed {
		logic high_first;
		logic parity_odd;
		logic stop_level;
		logic start_level;
		logic start_insert;
	} tbm_frame_cfg_t;

	typedef struct packed {
		logic level;
		logic oe;
	} tbm_pin_t;

	typedef enum logic [2:0] {
		TBM_TX_IDLE,
		TBM_TX_START,
		TBM_TX_DATA,
		TBM_TX_PARITY,
		TBM_TX_STOP
	} tbm_tx_state_t;

endpackage : tbm_pkg

// ==== rtl/tbm_monitor_mux.sv ====
// selects what drives the monitor output pin from the 4-bit source select.
// assumes the caller registers the result before it reaches the pad.
`timescale 1ns/1ps
`include "tbm_defines.svh"
module tbm_monitor_mux (
	input wire logic [3:0] sel,
	input wire tbm_pkg::tbm_mon_src_t src,
	output tbm_pkg::tbm_pin_t pin
);
	import tbm_pkg::*;

	always_comb begin
		pin = '0;
		case (sel)
			`TBM_SEL_LOW: begin
				pin.oe = 1'b1;
			end
			`TBM_SEL_HIGH: begin
				pin.oe = 1'b1;
				pin.level = 1'b1;
			end
			`TBM_SEL_TX_ENV: begin
				pin.oe = 1'b1;
				pin.level = src.tx_env;
			end
			`TBM_SEL_TX_ACTIVE: begin
				pin.oe = 1'b1;
				pin.level = src.tx_active;
			end
			`TBM_SEL_SECURE: begin
				pin.oe = 1'b1;
				pin.level = src.secure;
			end
			`TBM_SEL_RX_ENV: begin
				// only meaningful for type A at 106 kBd; passed through as is
				pin.oe = 1'b1;
				pin.level = src.rx_env;
			end
			`TBM_SEL_RX_ACTIVE: begin
				pin.oe = 1'b1;
				pin.level = src.rx_active;
			end
			`TBM_SEL_RX_BIT: begin
				pin.oe = 1'b1;
				pin.level = src.rx_bit;
			end
			default: begin
				pin = '0;
			end
		endcase
	end

endmodule : tbm_monitor_mux

// ==== rtl/tbm_tx_framer.sv ====
// serialises one byte per request: optional start bit, eight data bits,
// parity, stop. one bit per enabled clock; framing latched at request.
`timescale 1ns/1ps
`include "tbm_defines.svh"
module tbm_tx_framer (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	input wire tbm_pkg::tbm_frame_cfg_t cfg,
	input wire logic start,
	input wire logic [7:0] data,
	output logic ready,
	output logic tx_bit,
	output logic tx_active
);
	import tbm_pkg::*;

	tbm_tx_state_t state_r, state_nxt;
	tbm_frame_cfg_t cfg_r, cfg_nxt;
	logic [7:0] byte_r, byte_nxt;
	logic [2:0] idx_r, idx_nxt;
	logic bit_r, bit_nxt;
	logic active_r, active_nxt;
	logic ready_r, ready_nxt;

	function automatic logic pick_bit(input logic [7:0] b, input logic [2:0] i,
		input logic high_first);
		pick_bit = high_first ? b[3'h7 - i] : b[i];
	endfunction : pick_bit

	always_comb begin
		state_nxt = state_r;
		cfg_nxt = cfg_r;
		byte_nxt = byte_r;
		idx_nxt = idx_r;
		bit_nxt = bit_r;
		active_nxt = active_r;
		ready_nxt = ready_r;
		case (state_r)
			TBM_TX_IDLE: begin
				if (start) begin
					// settings are held for the whole frame so a write mid-frame cannot tear it
					cfg_nxt = cfg;
					byte_nxt = data;
					idx_nxt = 3'h0;
					active_nxt = 1'b1;
					ready_nxt = 1'b0;
					if (cfg.start_insert) begin
						state_nxt = TBM_TX_START;
						bit_nxt = cfg.start_level;
					end else begin
						state_nxt = TBM_TX_DATA;
						bit_nxt = pick_bit(data, 3'h0, cfg.high_first);
					end
				end
			end
			TBM_TX_START: begin
				state_nxt = TBM_TX_DATA;
				bit_nxt = pick_bit(byte_r, 3'h0, cfg_r.high_first);
			end
			TBM_TX_DATA: begin
				if (idx_r == `TBM_LAST_DATA_IDX) begin
					state_nxt = TBM_TX_PARITY;
					bit_nxt = (^byte_r) ^ cfg_r.parity_odd;
				end else begin
					idx_nxt = idx_r + 3'h1;
					bit_nxt = pick_bit(byte_r, idx_r + 3'h1, cfg_r.high_first);
				end
			end
			TBM_TX_PARITY: begin
				state_nxt = TBM_TX_STOP;
				bit_nxt = cfg_r.stop_level;
			end
			TBM_TX_STOP: begin
				state_nxt = TBM_TX_IDLE;
				bit_nxt = 1'b0;
				active_nxt = 1'b0;
				ready_nxt = 1'b1;
			end
			default: begin
				state_nxt = TBM_TX_IDLE;
				bit_nxt = 1'b0;
				active_nxt = 1'b0;
				ready_nxt = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= TBM_TX_IDLE;
			cfg_r <= '0;
			byte_r <= 8'h00;
			idx_r <= 3'h0;
			bit_r <= 1'b0;
			active_r <= 1'b0;
			ready_r <= 1'b1;
		end else if (en) begin
			state_r <= state_nxt;
			cfg_r <= cfg_nxt;
			byte_r <= byte_nxt;
			idx_r <= idx_nxt;
			bit_r <= bit_nxt;
			active_r <= active_nxt;
			ready_r <= ready_nxt;
		end
	end

	assign ready = ready_r;
	assign tx_bit = bit_r;
	assign tx_active = active_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence seq_taken_insert;
		en && state_r == TBM_TX_IDLE && start && cfg.start_insert;
	endsequence

	sequence seq_taken_plain;
		en && state_r == TBM_TX_IDLE && start && !cfg.start_insert;
	endsequence

	a_start_bit_level: assert property (seq_taken_insert |=>
		state_r == TBM_TX_START && bit_r == $past(cfg.start_level))
		else $error("start bit level wrong");
	a_start_bit_omitted: assert property (seq_taken_plain |=>
		state_r == TBM_TX_DATA && idx_r == 3'h0)
		else $error("start bit sent although disabled");
	a_data_bit_order: assert property (state_r == TBM_TX_DATA |->
		bit_r == (cfg_r.high_first ? byte_r[3'h7 - idx_r] : byte_r[idx_r]))
		else $error("data bit out of order");
	a_parity_bit_value: assert property (en && state_r == TBM_TX_DATA && idx_r == 3'h7 |=>
		state_r == TBM_TX_PARITY && bit_r == ((^byte_r) ^ cfg_r.parity_odd))
		else $error("parity bit wrong");
	a_stop_bit_level: assert property (en && state_r == TBM_TX_PARITY |=>
		state_r == TBM_TX_STOP && bit_r == cfg_r.stop_level)
		else $error("stop bit level wrong");

endmodule : tbm_tx_framer

// ==== rtl/tbm_top.sv ====
// monitor pin control and transmit bit framing registers with the
// byte framer and monitor pin selector behind them.
// assumes one 100 MHz clock and a host port that never needs a wait state.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "tbm_defines.svh"
module tbm_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic tx_start,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	output logic tx_serial,
	output logic tx_busy,
	input wire logic generic_secure_link_signal,
	input wire tbm_pkg::tbm_rx_sig_t rx_sig,
	output logic monitor_output_pin,
	output logic monitor_output_pin_oe,
	output logic fast_pad_switching
);
	import tbm_pkg::*;

	logic rst_meta_r, rst_sync_r;
	logic [7:0] mon_r, mon_nxt;
	logic [7:0] frm_r, frm_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	tbm_pin_t pin_r, pin_nxt;
	tbm_frame_cfg_t frame_cfg;
	tbm_mon_src_t mon_src;
	logic fr_bit, fr_active, fr_ready;

	// second stage is the only reader of the first
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	always_comb begin
		mon_nxt = mon_r;
		frm_nxt = frm_r;
		rdata_nxt = 8'h00;
		if (reg_wr) begin
			if (reg_addr == `TBM_ADDR_MONITOR) begin
				mon_nxt = reg_wdata & `TBM_MON_MASK;
			end
			if (reg_addr == `TBM_ADDR_FRAMING) begin
				frm_nxt = reg_wdata & `TBM_FRM_MASK;
			end
		end
		// unmapped reads answer zero
		if (reg_rd) begin
			if (reg_addr == `TBM_ADDR_MONITOR) begin
				rdata_nxt = mon_r;
			end else if (reg_addr == `TBM_ADDR_FRAMING) begin
				rdata_nxt = frm_r;
			end
		end
	end

	always_comb begin
		frame_cfg.high_first = frm_r[`TBM_FRM_HIGH_FIRST_BIT];
		frame_cfg.parity_odd = frm_r[`TBM_FRM_PARITY_BIT];
		frame_cfg.stop_level = frm_r[`TBM_FRM_STOP_BIT];
		frame_cfg.start_level = frm_r[`TBM_FRM_START_LEVEL_BIT];
		frame_cfg.start_insert = frm_r[`TBM_FRM_START_INSERT_BIT];
	end

	tbm_tx_framer u_framer (
		.clk(clk),
		.rst_n(rst_sync_r),
		.en(clk_en),
		.cfg(frame_cfg),
		.start(tx_start),
		.data(tx_data),
		.ready(fr_ready),
		.tx_bit(fr_bit),
		.tx_active(fr_active)
	);

	always_comb begin
		// envelope is the line level while a frame runs, low when idle
		mon_src.tx_env = fr_bit & fr_active;
		mon_src.tx_active = fr_active;
		mon_src.secure = generic_secure_link_signal;
		mon_src.rx_env = rx_sig.rx_env;
		mon_src.rx_active = rx_sig.rx_active;
		mon_src.rx_bit = rx_sig.rx_bit;
	end

	tbm_monitor_mux u_mux (
		.sel(mon_r[`TBM_MON_SEL_MSB:`TBM_MON_SEL_LSB]),
		.src(mon_src),
		.pin(pin_nxt)
	);

	always_ff @(posedge clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			mon_r <= `TBM_MON_RESET;
			frm_r <= `TBM_FRM_RESET;
			rdata_r <= 8'h00;
			pin_r <= '0;
		end else if (clk_en) begin
			mon_r <= mon_nxt;
			frm_r <= frm_nxt;
			rdata_r <= rdata_nxt;
			pin_r <= pin_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign monitor_output_pin = pin_r.level;
	assign monitor_output_pin_oe = pin_r.oe;
	assign fast_pad_switching = mon_r[`TBM_MON_FAST_BIT];
	assign tx_ready = fr_ready;
	assign tx_serial = fr_bit;
	assign tx_busy = fr_active;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sync_r);

	logic [3:0] sel_w;
	assign sel_w = mon_r[3:0];

	a_pin_tristate_low: assert property (clk_en && sel_w <= 4'h1 |=>
		!monitor_output_pin_oe)
		else $error("pin driven for codes 0 or 1");
	a_pin_tristate_high: assert property (clk_en && sel_w >= 4'ha |=>
		!monitor_output_pin_oe)
		else $error("pin driven for undefined code");
	a_pin_constant_level: assert property (clk_en && (sel_w == 4'h2 || sel_w == 4'h3) |=>
		monitor_output_pin_oe && monitor_output_pin == $past(sel_w[0]))
		else $error("constant level wrong");
	a_pin_tx_env: assert property (clk_en && sel_w == 4'h4 |=>
		monitor_output_pin_oe && monitor_output_pin == $past(fr_bit & fr_active))
		else $error("tx envelope not routed");
	a_pin_tx_active: assert property (clk_en && sel_w == 4'h5 |=>
		monitor_output_pin == $past(fr_active))
		else $error("tx active not routed");
	a_pin_secure: assert property (clk_en && sel_w == 4'h6 |=>
		monitor_output_pin == $past(generic_secure_link_signal))
		else $error("secure link signal not routed");
	a_pin_rx_env: assert property (clk_en && sel_w == 4'h7 |=>
		monitor_output_pin == $past(rx_sig.rx_env))
		else $error("rx envelope not routed");
	a_pin_rx_sigs: assert property (clk_en && (sel_w == 4'h8 || sel_w == 4'h9) |=>
		monitor_output_pin == ($past(sel_w[0]) ? $past(rx_sig.rx_bit) : $past(rx_sig.rx_active)))
		else $error("rx signal not routed");
	a_fast_pad_write: assert property (clk_en && reg_wr && reg_addr == `TBM_ADDR_MONITOR |=>
		fast_pad_switching == $past(reg_wdata[7]))
		else $error("fast pad bit not taken");
	a_reserved_read_zero: assert property (clk_en && reg_rd && reg_addr == `TBM_ADDR_FRAMING |=>
		(reg_rdata & ~`TBM_FRM_MASK) == 8'h00 && reg_rdata == $past(frm_r))
		else $error("framing read back wrong");

	// register side: masks, read back, and what a frozen clock enable must hold
	sequence seq_mon_write;
		clk_en && reg_wr && reg_addr == `TBM_ADDR_MONITOR;
	endsequence

	sequence seq_frm_write;
		clk_en && reg_wr && reg_addr == `TBM_ADDR_FRAMING;
	endsequence

	sequence seq_other_write;
		clk_en && reg_wr && reg_addr != `TBM_ADDR_MONITOR && reg_addr != `TBM_ADDR_FRAMING;
	endsequence

	sequence seq_mon_read;
		clk_en && reg_rd && reg_addr == `TBM_ADDR_MONITOR;
	endsequence

	sequence seq_other_read;
		clk_en && reg_rd && reg_addr != `TBM_ADDR_MONITOR && reg_addr != `TBM_ADDR_FRAMING;
	endsequence

	a_mon_write_mask: assert property (seq_mon_write |=>
		mon_r == ($past(reg_wdata) & `TBM_MON_MASK))
		else $error("monitor write not masked");
	a_frm_write_mask: assert property (seq_frm_write |=>
		frm_r == ($past(reg_wdata) & `TBM_FRM_MASK))
		else $error("framing write not masked");
	a_other_write_ignored: assert property (seq_other_write |=>
		$stable(mon_r) && $stable(frm_r))
		else $error("unmapped write changed a register");
	a_mon_read_back: assert property (seq_mon_read |=>
		reg_rdata == $past(mon_r) && (reg_rdata & ~`TBM_MON_MASK) == 8'h00)
		else $error("monitor read back wrong");
	a_unmapped_read_zero: assert property (seq_other_read |=>
		reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_read_data_drops: assert property (clk_en && !reg_rd |=>
		reg_rdata == 8'h00)
		else $error("read data outstayed its cycle");

	// the host port leaves one idle edge between a write and the read behind it
	a_write_then_read: assert property (seq_mon_write ##1 !reg_wr ##1 seq_mon_read |=>
		reg_rdata == ($past(reg_wdata, 3) & `TBM_MON_MASK))
		else $error("written value not read back");

	// a low enable holds registers, read data and pin alike
	a_stalled_regs_hold: assert property (!clk_en |=>
		$stable(mon_r) && $stable(frm_r) && $stable(reg_rdata) && $stable(pin_r))
		else $error("state moved while clock enable low");
	// pin side: every defined code drives, every other code rests low
	a_pin_driven_codes: assert property (clk_en && sel_w inside {[4'h2:4'h9]} |=>
		monitor_output_pin_oe)
		else $error("pin not driven for a defined code");
	a_pin_idle_level: assert property (clk_en && (sel_w <= 4'h1 || sel_w >= 4'ha) |=>
		!monitor_output_pin)
		else $error("undriven pin left at a level");
	a_pin_tx_env_idle: assert property (clk_en && sel_w == 4'h4 && !tx_busy |=>
		!monitor_output_pin)
		else $error("envelope high with no frame");

	// frame watcher: rebuilds the expected line from the pins and the latched
	// register, so a slip in the framer's own counters cannot vouch for itself;
	// it costs a few flops that synthesis drops, since nothing but checks reads them
	logic [3:0] busy_cnt_r, busy_cnt_nxt;
	logic [7:0] seen_frm_r, seen_frm_nxt;
	logic [7:0] seen_data_r, seen_data_nxt;
	logic [1:0] tail_r, tail_nxt;
	logic [3:0] data_pos;
	logic data_phase;
	logic exp_bit;

	always_comb begin
		busy_cnt_nxt = busy_cnt_r;
		seen_frm_nxt = seen_frm_r;
		seen_data_nxt = seen_data_r;
		tail_nxt = tail_r;
		if (tx_start && tx_ready) begin
			busy_cnt_nxt = 4'h0;
			seen_frm_nxt = frm_r;
			seen_data_nxt = tx_data;
		end else if (tx_busy) begin
			// last two bits on the line are parity and stop when the frame ends
			busy_cnt_nxt = busy_cnt_r + 4'h1;
			tail_nxt = {tail_r[0], tx_serial};
		end
	end

	always_ff @(posedge clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			busy_cnt_r <= 4'h0;
			seen_frm_r <= 8'h00;
			seen_data_r <= 8'h00;
			tail_r <= 2'b00;
		end else if (clk_en) begin
			busy_cnt_r <= busy_cnt_nxt;
			seen_frm_r <= seen_frm_nxt;
			seen_data_r <= seen_data_nxt;
			tail_r <= tail_nxt;
		end
	end

	always_comb begin
		data_pos = busy_cnt_r - {3'h0, seen_frm_r[`TBM_FRM_START_INSERT_BIT]};
		data_phase = tx_busy && (data_pos < 4'h8);
		if (seen_frm_r[`TBM_FRM_HIGH_FIRST_BIT]) begin
			exp_bit = seen_data_r[3'h7 - data_pos[2:0]];
		end else begin
			exp_bit = seen_data_r[data_pos[2:0]];
		end
	end

	sequence seq_frame_end;
		$fell(tx_busy);
	endsequence

	a_frame_start_bit: assert property (tx_busy && busy_cnt_r == 4'h0 &&
		seen_frm_r[`TBM_FRM_START_INSERT_BIT] |->
		tx_serial == seen_frm_r[`TBM_FRM_START_LEVEL_BIT])
		else $error("start bit level differs from register");

	a_frame_data_bits: assert property (data_phase |->
		tx_serial == exp_bit)
		else $error("data bit differs from byte taken");

	a_frame_length: assert property (seq_frame_end |->
		busy_cnt_r == (seen_frm_r[`TBM_FRM_START_INSERT_BIT] ?
		`TBM_FRAME_LEN_INSERT : `TBM_FRAME_LEN_PLAIN))
		else $error("frame length wrong");

	// parity covers the eight data bits only, never the start bit
	a_frame_parity: assert property (seq_frame_end |->
		tail_r[1] == ((^seen_data_r) ^ seen_frm_r[`TBM_FRM_PARITY_BIT]))
		else $error("parity bit differs from byte taken");

	a_frame_stop: assert property (seq_frame_end |->
		tail_r[0] == seen_frm_r[`TBM_FRM_STOP_BIT])
		else $error("stop bit level differs from register");

endmodule : tbm_top

// ==== test/tbm_top_bench.sv ====
// self-checking bench for the monitor pin and transmit framing registers.
// assumes tbm_top on a 100 MHz clock; the bench drives every input itself.
`timescale 1ns/1ps
`include "tbm_defines.svh"
module tbm_top_bench;
	import tbm_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic tx_start = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic tx_ready;
	logic tx_serial;
	logic tx_busy;
	logic generic_secure_link_signal = 1'b0;
	tbm_rx_sig_t rx_sig = '0;
	logic monitor_output_pin;
	logic monitor_output_pin_oe;
	logic fast_pad_switching;
	int failures = 0;
	int checks = 0;
	logic prv;

	tbm_top dut (
		.clk(clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.tx_start(tx_start),
		.tx_data(tx_data),
		.tx_ready(tx_ready),
		.tx_serial(tx_serial),
		.tx_busy(tx_busy),
		.generic_secure_link_signal(generic_secure_link_signal),
		.rx_sig(rx_sig),
		.monitor_output_pin(monitor_output_pin),
		.monitor_output_pin_oe(monitor_output_pin_oe),
		.fast_pad_switching(fast_pad_switching)
	);

	initial begin
		forever #5 clk = ~clk;
	end

	task automatic final_report;
		if ((failures == 0) && (checks > 0)) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : cmp8

	task automatic cmp1(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : cmp1

	// each access leaves one idle edge so no strobe is assigned twice in a step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		cmp8(reg_rdata, exp);
	endtask : rd

	function automatic logic [1:0] mon_exp(input logic [3:0] c, input logic [3:0] p);
		// framer idle here, so both transmit sources read low
		case (c)
			`TBM_SEL_LOW, `TBM_SEL_TX_ENV, `TBM_SEL_TX_ACTIVE: return 2'b10;
			`TBM_SEL_HIGH: return 2'b11;
			`TBM_SEL_SECURE: return {1'b1, p[3]};
			`TBM_SEL_RX_ENV: return {1'b1, p[2]};
			`TBM_SEL_RX_ACTIVE: return {1'b1, p[1]};
			`TBM_SEL_RX_BIT: return {1'b1, p[0]};
			default: return 2'b00;
		endcase
	endfunction : mon_exp

	// env picks code 4 (envelope) over code 5 (activity) on the monitor pin
	task automatic frame(input logic [7:0] cfg, input logic [7:0] d, input logic env);
		logic q[$];
		int n;
		q = {};
		if (cfg[0]) begin
			q.push_back(cfg[1]);
		end
		for (n = 0; n < 8; n++) begin
			q.push_back(cfg[7] ? d[7 - n] : d[n]);
		end
		q.push_back(^d ^ cfg[5]);
		q.push_back(cfg[3]);
		for (n = 0; (n < 20) && (tx_ready !== 1'b1); n++) begin
			@(posedge clk);
		end
		if (n == 20) begin
			failures++;
			final_report();
		end
		wr(`TBM_ADDR_FRAMING, cfg);
		@(posedge clk);
		tx_start <= 1'b1;
		tx_data <= d;
		@(posedge clk);
		tx_start <= 1'b0;
		prv = 1'b0;
		for (n = 0; n < q.size(); n++) begin
			#1;
			cmp1(tx_serial, q[n]);
			cmp1(tx_busy, 1'b1);
			cmp1(tx_ready, 1'b0);
			cmp1(monitor_output_pin, prv);
			prv = env ? (tx_serial & tx_busy) : tx_busy;
			@(posedge clk);
			// a request while busy must leave the frame untouched
			tx_start <= (n == 3);
		end
		#1;
		cmp1(tx_busy, 1'b0);
		cmp1(tx_ready, 1'b1);
		cmp1(tx_serial, 1'b0);
		cmp1(monitor_output_pin, prv);
		cmp1(monitor_output_pin_oe, 1'b1);
	endtask : frame

	initial begin
		int c;
		int p;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		cmp1(tx_ready, 1'b1);
		cmp1(monitor_output_pin_oe, 1'b0);
		cmp1(fast_pad_switching, 1'b0);
		rd(`TBM_ADDR_MONITOR, 8'h00);
		rd(`TBM_ADDR_FRAMING, 8'h00);
		wr(`TBM_ADDR_MONITOR, 8'hff);
		rd(`TBM_ADDR_MONITOR, 8'h8f);
		cmp1(fast_pad_switching, 1'b1);
		wr(`TBM_ADDR_FRAMING, 8'hff);
		rd(`TBM_ADDR_FRAMING, 8'hab);
		wr(`TBM_ADDR_MONITOR, 8'h70);
		rd(`TBM_ADDR_MONITOR, 8'h00);
		cmp1(fast_pad_switching, 1'b0);
		wr(`TBM_ADDR_FRAMING, 8'h54);
		rd(`TBM_ADDR_FRAMING, 8'h00);
		wr(8'h49, 8'hff);
		rd(8'h49, 8'h00);
		rd(8'h46, 8'h00);
		// a stalled clock enable must swallow the write
		@(posedge clk);
		clk_en <= 1'b0;
		wr(`TBM_ADDR_MONITOR, 8'h83);
		@(posedge clk);
		clk_en <= 1'b1;
		rd(`TBM_ADDR_MONITOR, 8'h00);
		for (c = 0; c < 16; c++) begin
			wr(`TBM_ADDR_MONITOR, {4'h0, c[3:0]});
			for (p = 0; p < 16; p++) begin
				@(posedge clk);
				generic_secure_link_signal <= p[3];
				rx_sig <= tbm_rx_sig_t'(p[2:0]);
				repeat (2) @(posedge clk);
				#1;
				cmp8({6'h00, monitor_output_pin_oe, monitor_output_pin},
					{6'h00, mon_exp(c[3:0], p[3:0])});
			end
		end
		for (c = 0; c < 32; c++) begin
			wr(`TBM_ADDR_MONITOR, c[0] ? 8'h04 : 8'h05);
			frame({c[4], 1'b0, c[3], 1'b0, c[2], 1'b0, c[1], c[0]},
				8'h5b ^ 8'(c * 37), c[0]);
		end
		frame(8'h01, 8'h01, 1'b1);
		final_report();
	end
endmodule : tbm_top_bench
